// ==== inc/evt_cfg_pkg.sv ====
package evt_cfg_pkg;

    // Register indices as printed; the register port addresses 16-bit words.
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] IRQ_EN_TWO_ADDR = 10'h004;
    localparam logic [ADDR_W-1:0] ZC_SETUP_ADDR = 10'h007;
    localparam logic [ADDR_W-1:0] DIP_LIMIT_ADDR = 10'h008;
    localparam logic [ADDR_W-1:0] MISSING_LIMIT_ADDR = 10'h009;
    localparam logic [ADDR_W-1:0] N_COMP_LIMIT_ADDR = 10'h00a;
    localparam logic [ADDR_W-1:0] N_MEAS_LIMIT_ADDR = 10'h00b;
    localparam logic [ADDR_W-1:0] V_DIST_LIMIT_ADDR = 10'h00c;
    localparam logic [ADDR_W-1:0] I_DIST_LIMIT_ADDR = 10'h00d;

    // Values after reset.
    localparam logic [15:0] IRQ_EN_TWO_RST = 16'h0000;
    localparam logic [15:0] ZC_SETUP_RST = 16'h0001;
    localparam logic [15:0] DIP_LIMIT_RST = 16'h0000;
    localparam logic [15:0] MISSING_LIMIT_RST = 16'h0000;
    localparam logic [15:0] N_COMP_LIMIT_RST = 16'hffff;
    localparam logic [15:0] N_MEAS_LIMIT_RST = 16'hffff;
    localparam logic [15:0] V_DIST_LIMIT_RST = 16'hffff;
    localparam logic [15:0] I_DIST_LIMIT_RST = 16'hffff;

    // Writable bits; every other position is reserved.
    localparam logic [15:0] IRQ_EN_TWO_MASK = 16'hceff;
    localparam logic [15:0] ZC_SETUP_MASK = 16'hffff;

    // Bit positions in the enable and status words.
    localparam int MEAS_NEUTRAL_BIT = 15;
    localparam int COMP_NEUTRAL_BIT = 14;
    localparam int V_DIST_BIT = 11;
    localparam int I_DIST_BIT = 10;
    localparam int HARMONIC_BIT = 9;

    // Field positions in the zero-crossing setup word.
    localparam int ZC_OFF_BIT = 0;
    localparam int ZC_MODE_LSB = 1;
    localparam int ZC_SRC_LSB = 7;
    localparam int ZC_PINS = 3;

    // Edge modes of a crossing pin.
    localparam logic [1:0] ZC_RISING = 2'h0;
    localparam logic [1:0] ZC_FALLING = 2'h1;
    localparam logic [1:0] ZC_BOTH = 2'h2;

    // Register port request from the serial front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
    } reg_req_s;

    // Measured quantities compared against the limits.
    typedef struct packed {
        logic [15:0] neutral_computed;
        logic [15:0] neutral_measured;
        logic [2:0][15:0] voltage_thd;
        logic [2:0][15:0] current_thd;
    } meas_s;

endpackage : evt_cfg_pkg

// ==== core/evt_cfg_regs.sv ====
`timescale 1ns/1ps

module evt_cfg_regs (
    input wire logic CORE_CLK_I, // System clock, 125 MHz.
    input wire logic RSTN_I, // Asynchronous reset, active low.
    input wire evt_cfg_pkg::reg_req_s REQ_I, // Register port request.
    output logic [15:0] RDATA_O, // Read data, registered.
    output logic RVALID_O, // Read data valid, one-cycle pulse.
    input wire logic [15:0] STATUS_TWO_I, // Current status word two.
    output logic INTERRUPT_OUT_TWO_O, // Interrupt two, active high.
    input wire evt_cfg_pkg::meas_s MEAS_I, // Measured quantities.
    output logic MEASURED_NEUTRAL_OVER_FLAG_O, // Measured neutral over.
    output logic COMPUTED_NEUTRAL_OVER_FLAG_O, // Computed neutral over.
    output logic VOLTAGE_DISTORTION_OVER_FLAG_O, // Voltage THD over.
    output logic CURRENT_DISTORTION_OVER_FLAG_O, // Current THD over.
    input wire logic [5:0] WAVE_SIGN_I, // Ia Ib Ic Ua Ub Uc, 1 = positive.
    output logic [2:0] CROSSING_PIN_O, // Crossing pulses, one cycle.
    output logic [15:0] VOLTAGE_DIP_LIMIT_O, // Sag detector limit.
    output logic [15:0] PHASE_MISSING_LIMIT_O // Phase loss limit.
);
    import evt_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [15:0] irq_en_q, irq_en_d;
    logic [15:0] zc_setup_q, zc_setup_d;
    logic [15:0] dip_limit_q, dip_limit_d;
    logic [15:0] missing_limit_q, missing_limit_d;
    logic [15:0] n_comp_limit_q, n_comp_limit_d;
    logic [15:0] n_meas_limit_q, n_meas_limit_d;
    logic [15:0] v_dist_limit_q, v_dist_limit_d;
    logic [15:0] i_dist_limit_q, i_dist_limit_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // Writes land on the next edge; reserved positions are masked off so a
    // careless host cannot make them read back as ones.
    always_comb begin
        irq_en_d = irq_en_q;
        zc_setup_d = zc_setup_q;
        dip_limit_d = dip_limit_q;
        missing_limit_d = missing_limit_q;
        n_comp_limit_d = n_comp_limit_q;
        n_meas_limit_d = n_meas_limit_q;
        v_dist_limit_d = v_dist_limit_q;
        i_dist_limit_d = i_dist_limit_q;
        if (REQ_I.wr) begin
            unique case (REQ_I.addr)
                IRQ_EN_TWO_ADDR: begin
                    irq_en_d = REQ_I.wdata & IRQ_EN_TWO_MASK;
                end
                ZC_SETUP_ADDR: begin
                    zc_setup_d = REQ_I.wdata & ZC_SETUP_MASK;
                end
                DIP_LIMIT_ADDR: begin
                    dip_limit_d = REQ_I.wdata;
                end
                MISSING_LIMIT_ADDR: begin
                    missing_limit_d = REQ_I.wdata;
                end
                N_COMP_LIMIT_ADDR: begin
                    n_comp_limit_d = REQ_I.wdata;
                end
                N_MEAS_LIMIT_ADDR: begin
                    n_meas_limit_d = REQ_I.wdata;
                end
                V_DIST_LIMIT_ADDR: begin
                    v_dist_limit_d = REQ_I.wdata;
                end
                I_DIST_LIMIT_ADDR: begin
                    i_dist_limit_d = REQ_I.wdata;
                end
                default: begin
                    // Unmapped write is dropped.
                end
            endcase
        end
    end

    // Read mux; unmapped addresses and reserved bits answer zero.
    always_comb begin
        rvalid_d = REQ_I.rd;
        rdata_d = 16'h0000;
        if (REQ_I.rd) begin
            unique case (REQ_I.addr)
                IRQ_EN_TWO_ADDR: rdata_d = irq_en_q;
                ZC_SETUP_ADDR: rdata_d = zc_setup_q;
                DIP_LIMIT_ADDR: rdata_d = dip_limit_q;
                MISSING_LIMIT_ADDR: rdata_d = missing_limit_q;
                N_COMP_LIMIT_ADDR: rdata_d = n_comp_limit_q;
                N_MEAS_LIMIT_ADDR: rdata_d = n_meas_limit_q;
                V_DIST_LIMIT_ADDR: rdata_d = v_dist_limit_q;
                I_DIST_LIMIT_ADDR: rdata_d = i_dist_limit_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Register stage for the configuration words and the read answer.
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_en_q <= IRQ_EN_TWO_RST;
            zc_setup_q <= ZC_SETUP_RST;
            dip_limit_q <= DIP_LIMIT_RST;
            missing_limit_q <= MISSING_LIMIT_RST;
            n_comp_limit_q <= N_COMP_LIMIT_RST;
            n_meas_limit_q <= N_MEAS_LIMIT_RST;
            v_dist_limit_q <= V_DIST_LIMIT_RST;
            i_dist_limit_q <= I_DIST_LIMIT_RST;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            irq_en_q <= irq_en_d;
            zc_setup_q <= zc_setup_d;
            dip_limit_q <= dip_limit_d;
            missing_limit_q <= missing_limit_d;
            n_comp_limit_q <= n_comp_limit_d;
            n_meas_limit_q <= n_meas_limit_d;
            v_dist_limit_q <= v_dist_limit_d;
            i_dist_limit_q <= i_dist_limit_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign RDATA_O = rdata_q;
    assign RVALID_O = rvalid_q;
    assign VOLTAGE_DIP_LIMIT_O = dip_limit_q;
    assign PHASE_MISSING_LIMIT_O = missing_limit_q;

    ////////////////////////////////////////////////////////////////////////
    // Threshold comparators.

    logic meas_over_q, meas_over_d;
    logic comp_over_q, comp_over_d;
    logic v_over_q, v_over_d;
    logic i_over_q, i_over_d;
    logic [2:0] v_phase_over;
    logic [2:0] i_phase_over;

    // Each phase is compared on its own; one phase over is enough.
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            assign v_phase_over[ph] =
                MEAS_I.voltage_thd[ph] > v_dist_limit_q;
            assign i_phase_over[ph] =
                MEAS_I.current_thd[ph] > i_dist_limit_q;
        end
    endgenerate

    // Flags follow the comparison as a level, and only while enabled, so a
    // disabled event never reaches the status word.
    always_comb begin
        meas_over_d = irq_en_q[MEAS_NEUTRAL_BIT]
            & (MEAS_I.neutral_measured > n_meas_limit_q);
        comp_over_d = irq_en_q[COMP_NEUTRAL_BIT]
            & (MEAS_I.neutral_computed > n_comp_limit_q);
        v_over_d = irq_en_q[V_DIST_BIT] & (|v_phase_over);
        i_over_d = irq_en_q[I_DIST_BIT] & (|i_phase_over);
    end

    // Registered so the flags leave the block glitch free.
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            meas_over_q <= 1'b0;
            comp_over_q <= 1'b0;
            v_over_q <= 1'b0;
            i_over_q <= 1'b0;
        end else begin
            meas_over_q <= meas_over_d;
            comp_over_q <= comp_over_d;
            v_over_q <= v_over_d;
            i_over_q <= i_over_d;
        end
    end

    assign MEASURED_NEUTRAL_OVER_FLAG_O = meas_over_q;
    assign COMPUTED_NEUTRAL_OVER_FLAG_O = comp_over_q;
    assign VOLTAGE_DISTORTION_OVER_FLAG_O = v_over_q;
    assign CURRENT_DISTORTION_OVER_FLAG_O = i_over_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt two.

    logic [15:0] irq_gate;
    logic irq_two_q, irq_two_d;

    // Per-bit gating of the status word by its enable.
    always_comb begin
        irq_gate = 16'h0000;
        irq_gate[MEAS_NEUTRAL_BIT] = irq_en_q[MEAS_NEUTRAL_BIT];
        irq_gate[COMP_NEUTRAL_BIT] = irq_en_q[COMP_NEUTRAL_BIT];
        irq_gate[V_DIST_BIT] = irq_en_q[V_DIST_BIT];
        irq_gate[I_DIST_BIT] = irq_en_q[I_DIST_BIT];
        irq_gate[HARMONIC_BIT] = irq_en_q[HARMONIC_BIT];
        irq_gate[7:0] = irq_en_q[7:0];
        irq_two_d = |(STATUS_TWO_I & irq_gate);
    end

    // Registered so the pin never glitches while the mask is rewritten.
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_two_q <= 1'b0;
        end else begin
            irq_two_q <= irq_two_d;
        end
    end

    assign INTERRUPT_OUT_TWO_O = irq_two_q;

    ////////////////////////////////////////////////////////////////////////
    // Zero-crossing pins.

    logic [5:0] sign_q, sign_d;
    logic [5:0] rise;
    logic [5:0] fall;
    logic [2:0] zc_q, zc_d;

    // The sign inputs come from the datapath on this clock, so no
    // synchroniser; the previous sample yields both edge kinds.
    always_comb begin
        sign_d = WAVE_SIGN_I;
        rise = WAVE_SIGN_I & ~sign_q;
        fall = ~WAVE_SIGN_I & sign_q;
    end

    genvar pin;
    generate
        for (pin = 0; pin < ZC_PINS; pin++) begin : g_pin
            logic [2:0] src;
            logic [1:0] mode;
            logic [2:0] idx;
            logic hit;
            assign src = zc_setup_q[ZC_SRC_LSB + 3*pin +: 3];
            assign mode = zc_setup_q[ZC_MODE_LSB + 2*pin +: 2];
            // Voltages sit at 0..2, currents at 3..5 of the sign vector.
            assign idx = src[2] ? ({1'b0, src[1:0]} + 3'h3) : {1'b0, src[1:0]};
            // Codes 011 and 111 hold the pin low.
            always_comb begin
                hit = 1'b0;
                if (src[1:0] != 2'h3) begin
                    unique case (mode)
                        ZC_RISING: hit = rise[idx];
                        ZC_FALLING: hit = fall[idx];
                        ZC_BOTH: hit = rise[idx] | fall[idx];
                        default: hit = 1'b0;
                    endcase
                end
                zc_d[pin] = hit & ~zc_setup_q[ZC_OFF_BIT];
            end
        end
    endgenerate

    // Sign history and pin pulses.
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sign_q <= 6'h00;
            zc_q <= 3'h0;
        end else begin
            sign_q <= sign_d;
            zc_q <= zc_d;
        end
    end

    assign CROSSING_PIN_O = zc_q;

endmodule : evt_cfg_regs

// ==== tb/evt_cfg_regs_properties.sv ====
`timescale 1ns/1ps
// Port-level checks of the event configuration bank.
module evt_cfg_regs_properties (
    input wire logic CORE_CLK_I, // System clock.
    input wire logic RSTN_I, // Reset, active low.
    input wire evt_cfg_pkg::reg_req_s REQ_I, // Register request.
    input wire logic [15:0] RDATA_O, // Read data.
    input wire logic RVALID_O, // Read data valid.
    input wire logic [15:0] STATUS_TWO_I, // Status word two.
    input wire logic INTERRUPT_OUT_TWO_O, // Interrupt two.
    input wire evt_cfg_pkg::meas_s MEAS_I, // Measured values.
    input wire logic MEASURED_NEUTRAL_OVER_FLAG_O, // Measured over.
    input wire logic COMPUTED_NEUTRAL_OVER_FLAG_O, // Computed over.
    input wire logic [2:0] CROSSING_PIN_O, // Crossing pulses.
    input wire logic [15:0] VOLTAGE_DIP_LIMIT_O, // Dip limit.
    input wire logic [15:0] PHASE_MISSING_LIMIT_O // Missing limit.
);
    import evt_cfg_pkg::*;
    ////////////////////////////////////////////////////////////
    // One clock domain, so clocking and reset are given once.
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    chk_read_answer: assert property (REQ_I.rd |=> RVALID_O)
        else $error("read not answered next cycle");
    chk_valid_cause: assert property (RVALID_O |-> $past(REQ_I.rd))
        else $error("read valid without a read");
    chk_rsvd_zero: assert property ((REQ_I.rd &&
        REQ_I.addr == IRQ_EN_TWO_ADDR) |=> !(|(RDATA_O & ~IRQ_EN_TWO_MASK)))
        else $error("reserved enable bits read nonzero");
    chk_unmapped_zero: assert property ((REQ_I.rd &&
        REQ_I.addr == 10'h005) |=> RDATA_O == 16'h0000)
        else $error("unmapped read nonzero");
    chk_irq_rsvd: assert property (!(|(STATUS_TWO_I &
        IRQ_EN_TWO_MASK)) |=> !INTERRUPT_OUT_TWO_O)
        else $error("interrupt without a usable status bit");
    chk_irq_enable_off: assert property ((REQ_I.wr &&
        REQ_I.addr == IRQ_EN_TWO_ADDR && REQ_I.wdata == 16'h0000)
        |=> ##1 !INTERRUPT_OUT_TWO_O) else $error("interrupt while disabled");
    chk_dip_write: assert property ((REQ_I.wr &&
        REQ_I.addr == DIP_LIMIT_ADDR)
        |=> VOLTAGE_DIP_LIMIT_O == $past(REQ_I.wdata))
        else $error("dip limit not written");
    chk_missing_hold: assert property (!(REQ_I.wr &&
        REQ_I.addr == MISSING_LIMIT_ADDR) |=> $stable(PHASE_MISSING_LIMIT_O))
        else $error("missing limit changed without a write");
    chk_meas_zero: assert property (
        MEAS_I.neutral_measured == 16'h0000
        |=> !MEASURED_NEUTRAL_OVER_FLAG_O)
        else $error("measured flag at zero");
    chk_comp_zero: assert property (
        MEAS_I.neutral_computed == 16'h0000
        |=> !COMPUTED_NEUTRAL_OVER_FLAG_O)
        else $error("computed flag at zero");
    chk_pin_pulse: assert property (
        CROSSING_PIN_O[0] |=> !CROSSING_PIN_O[0])
        else $error("crossing pulse longer than a cycle");
    cover property (RVALID_O);
    cover property (INTERRUPT_OUT_TWO_O);
    cover property (CROSSING_PIN_O != 3'h0);
endmodule : evt_cfg_regs_properties

bind evt_cfg_regs evt_cfg_regs_properties evt_cfg_regs_properties_inst (
    .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .REQ_I(REQ_I),
    .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .STATUS_TWO_I(STATUS_TWO_I),
    .INTERRUPT_OUT_TWO_O(INTERRUPT_OUT_TWO_O), .MEAS_I(MEAS_I),
    .MEASURED_NEUTRAL_OVER_FLAG_O(MEASURED_NEUTRAL_OVER_FLAG_O),
    .COMPUTED_NEUTRAL_OVER_FLAG_O(COMPUTED_NEUTRAL_OVER_FLAG_O),
    .CROSSING_PIN_O(CROSSING_PIN_O), .VOLTAGE_DIP_LIMIT_O(VOLTAGE_DIP_LIMIT_O),
    .PHASE_MISSING_LIMIT_O(PHASE_MISSING_LIMIT_O));

// ==== tb/evt_cfg_host.sv ====
`timescale 1ns/1ps
// Host processor side of the register word port.
module evt_cfg_host (
    input wire logic CORE_CLK_I, // System clock.
    output evt_cfg_pkg::reg_req_s REQ_O, // Request to the bank.
    input wire logic [15:0] RDATA_I, // Read data.
    input wire logic RVALID_I // Read data valid.
);
    import evt_cfg_pkg::*;
    initial REQ_O = '0;
    // Released strobes drop and address and data flip, so a stale address never looks live.
    task automatic idle();
        REQ_O.wr = 1'b0;
        REQ_O.rd = 1'b0;
        REQ_O.addr = ~REQ_O.addr;
        REQ_O.wdata = ~REQ_O.wdata;
    endtask : idle
    // Reserved positions are cleared through the writable mask m.
    task automatic wr(input logic [9:0] a, input logic [15:0] d,
                      input logic [15:0] m);
        @(posedge CORE_CLK_I);
        #1;
        REQ_O = '{1'b1, 1'b0, a, d & m};
        @(posedge CORE_CLK_I);
        #1;
        idle();
    endtask : wr
    // The answer stands for the cycle after the taking edge.
    task automatic rd(input logic [9:0] a, output logic [15:0] d,
                      output logic ok);
        @(posedge CORE_CLK_I);
        #1;
        REQ_O = '{1'b0, 1'b1, a, 16'h0000};
        @(posedge CORE_CLK_I);
        #1;
        ok = RVALID_I;
        d = RDATA_I;
        idle();
    endtask : rd
endmodule : evt_cfg_host

// ==== tb/evt_cfg_regs_test.sv ====
`timescale 1ns/1ps
// Self-checking bench of the event configuration bank.
module evt_cfg_regs_test;
    import evt_cfg_pkg::*;
    logic clk, rstn, rvalid, irq;
    reg_req_s req;
    logic [15:0] rdata, status, dip, miss, v;
    meas_s meas;
    logic [3:0] flags;
    logic [5:0] sign;
    logic [2:0] pins, acc;
    int n_mismatch, compares;
    logic [9:0] at [8] = '{IRQ_EN_TWO_ADDR, ZC_SETUP_ADDR, DIP_LIMIT_ADDR,
        MISSING_LIMIT_ADDR, N_COMP_LIMIT_ADDR, N_MEAS_LIMIT_ADDR,
        V_DIST_LIMIT_ADDR, I_DIST_LIMIT_ADDR};
    logic [15:0] rt [8] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000,
        16'hffff, 16'hffff, 16'hffff, 16'hffff};
    evt_cfg_host evt_cfg_host_inst (.CORE_CLK_I(clk), .REQ_O(req),
        .RDATA_I(rdata), .RVALID_I(rvalid));
    evt_cfg_regs evt_cfg_regs_inst (.CORE_CLK_I(clk), .RSTN_I(rstn),
        .REQ_I(req), .RDATA_O(rdata), .RVALID_O(rvalid),
        .STATUS_TWO_I(status), .INTERRUPT_OUT_TWO_O(irq), .MEAS_I(meas),
        .MEASURED_NEUTRAL_OVER_FLAG_O(flags[3]),
        .COMPUTED_NEUTRAL_OVER_FLAG_O(flags[2]),
        .VOLTAGE_DISTORTION_OVER_FLAG_O(flags[1]),
        .CURRENT_DISTORTION_OVER_FLAG_O(flags[0]), .WAVE_SIGN_I(sign),
        .CROSSING_PIN_O(pins), .VOLTAGE_DIP_LIMIT_O(dip),
        .PHASE_MISSING_LIMIT_O(miss));
    ////////////////////////////////////////////////////////////
    // Free-running 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input string nm, input logic [15:0] s,
                         input logic [15:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic rd_chk(input string nm, input logic [9:0] a,
                          input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        evt_cfg_host_inst.rd(a, d, ok);
        check({nm, " valid"}, {15'h0000, ok}, 16'h0001);
        check(nm, d, e);
    endtask : rd_chk
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    // Any pulse in three cycles after the sign change counts.
    task automatic zc(input logic [15:0] cfg, input logic [5:0] a,
                      input logic [5:0] b, input logic [2:0] e);
        evt_cfg_host_inst.wr(ZC_SETUP_ADDR, cfg, ZC_SETUP_MASK);
        sign = a;
        repeat (3) @(posedge clk);
        #1;
        sign = b;
        acc = 3'h0;
        repeat (3) begin
            @(posedge clk);
            #1;
            acc |= pins;
        end
        check("crossing pins", {13'h0000, acc}, {13'h0000, e});
    endtask : zc
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // A hung handshake is cut off far beyond the expected run.
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        rstn = 1'b0;
        status = 16'h0000;
        meas = '0;
        sign = 6'h00;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset value", at[i], rt[i]);
            evt_cfg_host_inst.wr(at[i], 16'hffff, 16'hffff);
            v = (i == 0) ? IRQ_EN_TWO_MASK : 16'hffff;
            rd_chk("all ones", at[i], v);
            evt_cfg_host_inst.wr(at[i], 16'h5aa5, v);
            rd_chk("pattern", at[i], 16'h5aa5 & v);
        end
        check("dip limit", dip, 16'h5aa5);
        check("missing limit", miss, 16'h5aa5);
        evt_cfg_host_inst.wr(10'h005, 16'h1234, 16'hffff);
        rd_chk("unmapped", 10'h005, 16'h0000);
        $display("register test done");
        // Each enable position alone against its own and other flags.
        for (int b = 0; b < 16; b++) begin
            evt_cfg_host_inst.wr(IRQ_EN_TWO_ADDR, 16'h0001 << b, 16'hffff);
            status = ~(16'h0001 << b);
            settle();
            check("irq others", {15'h0000, irq}, 16'h0000);
            status = 16'h0001 << b;
            settle();
            v = {15'h0000, IRQ_EN_TWO_MASK[b]};
            check("irq own", {15'h0000, irq}, v);
        end
        status = 16'h0000;
        $display("interrupt test done");
        for (int i = 4; i < 8; i++)
            evt_cfg_host_inst.wr(at[i], 16'h0064, 16'hffff);
        evt_cfg_host_inst.wr(IRQ_EN_TWO_ADDR, 16'hcc00, IRQ_EN_TWO_MASK);
        meas = {16'h0064, 16'h0064, {3{16'h0064}}, {3{16'h0064}}};
        settle();
        check("flags at limit", {12'h000, flags}, 16'h0000);
        meas = {16'h0065, 16'h0065, {3{16'h0065}}, {3{16'h0065}}};
        settle();
        check("flags over", {12'h000, flags}, 16'h000f);
        meas = {16'h0064, 16'h0064, 16'h0065, 16'h0064, 16'h0064,
                16'h0064, 16'h0064, 16'h0065};
        settle();
        check("one phase over", {12'h000, flags}, 16'h0003);
        // Distinct neutral limits catch a swap of the two limit words.
        evt_cfg_host_inst.wr(N_MEAS_LIMIT_ADDR, 16'h0066, 16'hffff);
        meas = {16'h0000, 16'h0065, 96'h0};
        settle();
        check("measured own limit", {12'h000, flags}, 16'h0000);
        meas = {16'h0000, 16'h0067, 96'h0};
        settle();
        check("measured only", {12'h000, flags}, 16'h0008);
        meas = {16'h0065, 16'h0000, 96'h0};
        settle();
        check("computed only", {12'h000, flags}, 16'h0004);
        evt_cfg_host_inst.wr(IRQ_EN_TWO_ADDR, 16'h0000, IRQ_EN_TWO_MASK);
        settle();
        check("flags gated", {12'h000, flags}, 16'h0000);
        $display("limit test done");
        // A second reset in mid-run must bring back every reset value.
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        check("flags after reset", {12'h000, flags}, 16'h0000);
        for (int i = 0; i < 8; i++)
            rd_chk("reset again", at[i], rt[i]);
        $display("second reset test done");
        for (int s = 0; s < 8; s++) begin
            v = {s[2:0], s[2:0], s[2:0], 7'h00};
            acc = (s == 3 || s == 7) ? 3'h0 : 3'h7;
            zc(v, 6'h00, (s == 3 || s == 7) ? 6'h3f :
               6'h01 << (s[2] ? s[1:0] + 3 : s[1:0]), acc);
        end
        for (int m = 0; m < 4; m++) begin
            v = {9'h000, m[1:0], m[1:0], m[1:0], 1'b0};
            zc(v, 6'h00, 6'h01, (m == 0 || m == 2) ? 3'h7 : 3'h0);
            zc(v, 6'h01, 6'h00, (m == 1 || m == 2) ? 3'h7 : 3'h0);
        end
        // Distinct settings per pin catch swapped field positions.
        zc({3'h4, 3'h1, 3'h0, 7'h00}, 6'h00, 6'h02, 3'h2);
        zc({9'h000, 2'h3, 2'h1, 2'h0, 1'b0}, 6'h00, 6'h01, 3'h1);
        zc(16'h0055, 6'h00, 6'h01, 3'h0);
        $display("crossing test done");
        report_and_stop();
    end
endmodule : evt_cfg_regs_test
